// >>> core/retry_sequencer.sv
// Fault auto-retry sequencer with register port and interrupt
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Retry limit 0..10, default 0 disables
// - Nonzero limit: log, clear running faults
// - Wait delay, restart only if start asserted
// - Reload budget after five healthy minutes
// - Budget spent: latch faulted, show code
// - Only listed faults retry automatically
// - No retry during tuning or identification
// - Retry delay 1..60 s, default 8
// - Show countdown prefix and seconds
// - Halt key or reset aborts, clears
// - After reset restart if start held
// - Phase loss fault only when enabled
module retry_sequencer #(
  parameter int TICK_CYCLES_P = retry_pkg::TICK_CYCLES,
  parameter int HEALTHY_S_P = retry_pkg::HEALTHY_RUN_SECONDS
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [retry_pkg::FAULT_W-1:0] fault_i,
  input wire logic phase_missing_i,
  input wire logic start_i,
  input wire logic fault_reset_i,
  input wire logic halt_key_i,
  input wire logic self_tune_i,
  input wire logic vhz_ident_i,
  output logic run_o,
  output logic faulted_o,
  output logic [retry_pkg::FAULT_W-1:0] fault_code_o,
  output logic countdown_o,
  output logic [7:0] disp_prefix_o,
  output logic [5:0] disp_seconds_o,
  output logic irq_o
);
  import retry_pkg::*;
  typedef struct packed {
    seq_state_type st;
    logic [3:0] limit;
    logic [5:0] delay;
    logic phase_en;
    logic [3:0] budget;
    logic [5:0] secs;
    logic [8:0] healthy;
    logic [FAULT_W-1:0] flog;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic [31:0] rdata;
    logic start_d;
  } seq_state_q_type;
  seq_state_q_type q, next_q;
  tick_if tk ();
  logic [FAULT_W-1:0] live;
  logic any_fault, eligible, clear_req, retry_ok, start_edge;
  logic ctrl_wr;
  logic [IRQ_W-1:0] ev;
  function automatic logic [3:0] clamp_limit(input logic [3:0] v);
    clamp_limit = (v > RETRY_LIMIT_MAX) ? RETRY_LIMIT_MAX : v;
  endfunction : clamp_limit
  function automatic logic [5:0] clamp_delay(input logic [5:0] v);
    if (v < RETRY_DELAY_MIN) clamp_delay = RETRY_DELAY_MIN;
    else if (v > RETRY_DELAY_MAX) clamp_delay = RETRY_DELAY_MAX;
    else clamp_delay = v;
  endfunction : clamp_delay
  second_tick #(.CYCLES(TICK_CYCLES_P)) u_tick (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .t(tk.source)
  );
  // Timer restarts on entry so every counted second is whole
  assign tk.clear = (next_q.st != q.st) &&
    ((next_q.st == ST_RUN) || (next_q.st == ST_WAIT));
  always_comb begin
    live = fault_i;
    live[FLT_PHASE_LOSS] = phase_missing_i & q.phase_en;
  end
  assign any_fault = |live;
  assign eligible = ((live & ~RETRY_ELIGIBLE_MASK) == '0);
  assign clear_req = halt_key_i | fault_reset_i;
  assign retry_ok = (q.limit != 4'h0) && !self_tune_i && !vhz_ident_i;
  assign start_edge = start_i & ~q.start_d;
  assign ctrl_wr = wr_i && (addr_i == REG_CTRL);
  always_comb begin
    next_q = q;
    ev = '0;
    next_q.start_d = start_i;
    next_q.rdata = 32'h0;
    case (q.st)
      ST_IDLE: begin
        if (start_edge && !any_fault) begin
          next_q.st = ST_RUN;
          next_q.healthy = 9'h0;
        end
      end
      ST_RUN: begin
        if (any_fault) begin
          next_q.flog = live;
          ev[IRQ_FAULT] = 1'b1;
          if (retry_ok && eligible && q.budget != 4'h0) begin
            next_q.st = ST_WAIT;
            next_q.budget = q.budget - 4'h1;
            next_q.secs = q.delay;
          end else begin
            next_q.st = ST_LATCHED;
            ev[IRQ_LATCH] = 1'b1;
          end
        end else if (!start_i) begin
          next_q.st = ST_IDLE;
        end else if (tk.tick) begin
          if (q.healthy == 9'(HEALTHY_S_P - 1)) begin
            next_q.budget = q.limit;
          end else begin
            next_q.healthy = q.healthy + 9'h1;
          end
        end
      end
      ST_WAIT: begin
        if (clear_req) begin
          next_q.st = start_i ? ST_RUN : ST_IDLE;
          next_q.healthy = 9'h0;
        end else if (tk.tick) begin
          if (q.secs == 6'h0) begin
            ev[IRQ_RETRY] = 1'b1;
            next_q.st = start_i ? ST_RUN : ST_IDLE;
            next_q.healthy = 9'h0;
          end else begin
            next_q.secs = q.secs - 6'h1;
          end
        end
      end
      ST_LATCHED: begin
        if (clear_req && !any_fault) begin
          next_q.st = start_i ? ST_RUN : ST_IDLE;
          next_q.healthy = 9'h0;
          next_q.budget = q.limit;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
    if (wr_i) begin
      case (addr_i)
        REG_CTRL: begin
          next_q.limit = clamp_limit(wdata_i[CTRL_LIMIT_LSB +: 4]);
          next_q.delay = clamp_delay(wdata_i[CTRL_DELAY_LSB +: 6]);
          next_q.phase_en = wdata_i[CTRL_PHASE_EN_BIT];
          next_q.budget = clamp_limit(wdata_i[CTRL_LIMIT_LSB +: 4]);
        end
        REG_IRQ_STAT: next_q.istat = q.istat & ~wdata_i[IRQ_W-1:0];
        REG_IRQ_MASK: next_q.imask = wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    next_q.istat = next_q.istat | ev;
    if (rd_i) begin
      case (addr_i)
        REG_CTRL: next_q.rdata = {21'h0, q.phase_en, q.delay, q.limit};
        REG_STATUS: next_q.rdata = {16'h0, q.healthy[5:0], q.secs, q.budget};
        REG_IRQ_STAT: next_q.rdata = {29'h0, q.istat};
        REG_IRQ_MASK: next_q.rdata = {29'h0, q.imask};
        REG_FAULT_LOG: next_q.rdata = {16'h0, q.flog};
        default: next_q.rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      q.limit <= RETRY_LIMIT_RESET;
      q.budget <= RETRY_LIMIT_RESET;
      q.delay <= RETRY_DELAY_RESET;
      q.phase_en <= PHASE_LOSS_EN_RESET;
      q.st <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end
  assign rdata_o = q.rdata;
  assign run_o = (q.st == ST_RUN);
  assign faulted_o = (q.st == ST_LATCHED);
  assign fault_code_o = q.flog;
  assign countdown_o = (q.st == ST_WAIT);
  assign disp_prefix_o = (q.st == ST_WAIT) ? COUNTDOWN_PREFIX : 8'h00;
  assign disp_seconds_o = q.secs;
  assign irq_o = |(q.istat & q.imask);

  sequence s_fault_retry;
    (q.st == ST_RUN) && any_fault && retry_ok && eligible && (q.budget != 4'h0);
  endsequence
  AST_RETRY_ENTERS_WAIT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_fault_retry |=> countdown_o && (disp_seconds_o == $past(q.delay)))
    else $error("eligible fault did not start countdown");
  AST_NO_RETRY_ZERO: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.limit == 4'h0) && run_o && any_fault |=> faulted_o)
    else $error("zero limit must latch fault");
  AST_INELIGIBLE_LATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && any_fault && !eligible |=> faulted_o)
    else $error("ineligible fault must latch");
  AST_TUNE_BLOCK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && any_fault && (self_tune_i || vhz_ident_i) |=> !countdown_o)
    else $error("retry during tuning");
  AST_COUNT_DOWN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    countdown_o && tk.tick && !clear_req && (q.secs != 6'h0)
      |=> disp_seconds_o == $past(q.secs) - 6'h1)
    else $error("countdown step wrong");
  AST_ABORT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    countdown_o && clear_req |=> !countdown_o && (run_o == $past(start_i)))
    else $error("abort did not clear countdown");
  AST_RESTART: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    countdown_o && tk.tick && !clear_req && (q.secs == 6'h0) |=> run_o == $past(start_i))
    else $error("restart decision wrong");
  AST_PHASE_OFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && !q.phase_en && (fault_i == '0) |=> !faulted_o)
    else $error("phase loss raised while disabled");
  AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    faulted_o && !clear_req |=> faulted_o && $stable(fault_code_o))
    else $error("latched state left without reset");

  AST_BUDGET_DEC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_fault_retry ##0 !ctrl_wr |=> q.budget == $past(q.budget) - 4'h1)
    else $error("retry did not spend one attempt");

  AST_SPENT_LATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && any_fault && (q.budget == 4'h0) |=> faulted_o)
    else $error("spent budget did not latch");

  AST_LOG_FAULT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && any_fault |=> fault_code_o == $past(live))
    else $error("fault not logged");

  AST_FAULT_IRQ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && any_fault |=> q.istat[IRQ_FAULT])
    else $error("fault event not flagged");

  // Register and timer sanity
  AST_LIMIT_RANGE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    q.limit <= RETRY_LIMIT_MAX)
    else $error("retry limit out of range");

  AST_DELAY_RANGE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.delay >= RETRY_DELAY_MIN) && (q.delay <= RETRY_DELAY_MAX))
    else $error("retry delay out of range");

  // Healthy-run window just completed
  sequence s_healthy_done;
    (q.st == ST_RUN) && !any_fault && start_i && tk.tick &&
      (q.healthy == 9'(HEALTHY_S_P - 1));
  endsequence
  AST_HEALTHY_RELOAD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_healthy_done ##0 !ctrl_wr |=> q.budget == $past(q.limit))
    else $error("budget not restored after healthy run");

  AST_NO_EARLY_RELOAD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && (q.healthy != 9'(HEALTHY_S_P - 1)) && !ctrl_wr |=> q.budget <= $past(q.budget))
    else $error("budget restored too early");

  AST_WAIT_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    countdown_o && !tk.tick && !clear_req |=> countdown_o && $stable(disp_seconds_o))
    else $error("countdown moved without a tick");

  AST_RETRY_IRQ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    countdown_o && tk.tick && !clear_req && (q.secs == 6'h0) |=> q.istat[IRQ_RETRY])
    else $error("retry expiry not flagged");

  // Latched fault released by the operator
  sequence s_latch_clear;
    faulted_o && clear_req && !any_fault;
  endsequence
  AST_LATCH_CLEAR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_latch_clear |=> run_o == $past(start_i))
    else $error("restart after reset wrong");

  AST_LATCH_RELOAD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_latch_clear ##0 !ctrl_wr |=> q.budget == $past(q.limit))
    else $error("budget not restored after reset");

  AST_START_RUN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.st == ST_IDLE) && start_edge && !any_fault |=> run_o)
    else $error("start edge did not run");

  AST_STOP_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    run_o && !any_fault && !start_i |=> (q.st == ST_IDLE))
    else $error("run kept without start");

  AST_IRQ_STICKY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    q.istat[IRQ_FAULT] && !(wr_i && (addr_i == REG_IRQ_STAT) && wdata_i[IRQ_FAULT])
      |=> q.istat[IRQ_FAULT])
    else $error("status bit lost without clear");

  AST_READ_IDLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");

  AST_TICK_SINGLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tk.tick |=> !tk.tick)
    else $error("tick longer than one cycle");
endmodule : retry_sequencer
`default_nettype wire

// >>> core/second_tick.sv
// One-second tick generator
`timescale 1ns/1ps
`default_nettype none
module second_tick #(
  parameter int CYCLES = retry_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  tick_if.source t
);
  import retry_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tick_state_type;
  tick_state_type q, next_q;
  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (t.clear) begin
      next_q.cnt = 32'h0;
    end else if (q.cnt == 32'(CYCLES - 1)) begin
      next_q.cnt = 32'h0;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
  assign t.tick = q.tick;
endmodule : second_tick
`default_nettype wire

// >>> inc/retry_pkg.sv
// Constants and types for the fault auto-retry sequencer
package retry_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int HEALTHY_RUN_MIN = 5;
  localparam int HEALTHY_RUN_SECONDS = HEALTHY_RUN_MIN * 60;
  localparam logic [3:0] RETRY_LIMIT_MAX = 4'hA;
  localparam logic [3:0] RETRY_LIMIT_RESET = 4'h0;
  localparam logic [5:0] RETRY_DELAY_MIN = 6'h01;
  localparam logic [5:0] RETRY_DELAY_MAX = 6'h3C;
  localparam logic [5:0] RETRY_DELAY_RESET = 6'h08;
  localparam logic PHASE_LOSS_EN_RESET = 1'b1;
  localparam int FAULT_W = 16;
  // Fault bit positions
  localparam int FLT_ANALOG_LOSS = 0;
  localparam int FLT_BYPASS = 1;
  localparam int FLT_GROUND = 2;
  localparam int FLT_HIGH_LINE = 3;
  localparam int FLT_HIGH_BUS = 4;
  localparam int FLT_LOW_BUS = 5;
  localparam int FLT_NET_LOSS = 6;
  localparam int FLT_OC_STEADY = 7;
  localparam int FLT_OC_ACCEL = 8;
  localparam int FLT_OC_BRAKE = 9;
  localparam int FLT_OVERTEMP = 10;
  localparam int FLT_OVERLOAD = 11;
  localparam int FLT_BUS_ASYM = 12;
  localparam int FLT_PHASE_LOSS = 13;
  localparam int FLT_OTHER_A = 14;
  localparam int FLT_OTHER_B = 15;
  localparam logic [FAULT_W-1:0] RETRY_ELIGIBLE_MASK = 16'h1FFF;
  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_FAULT_LOG = 4'h4;
  localparam int CTRL_LIMIT_LSB = 0;
  localparam int CTRL_DELAY_LSB = 4;
  localparam int CTRL_PHASE_EN_BIT = 10;
  // Interrupt status bits
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_RETRY = 1;
  localparam int IRQ_LATCH = 2;
  localparam int IRQ_W = 3;
  localparam logic [7:0] COUNTDOWN_PREFIX = 8'hA5;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_WAIT = 2'b11,
    ST_LATCHED = 2'b10
  } seq_state_type;
endpackage : retry_pkg

// >>> inc/tick_if.sv
// Tick and timer carrier between the sequencer and its timer
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic tick;
  logic clear;
  modport source (output tick, input clear);
  modport sink (input tick, output clear);
endinterface : tick_if
`default_nettype wire

// >>> testbench/fault_auto_retry_sequencer_test.sv
// Testbench for the fault auto-retry sequencer
`timescale 1ns/1ps
`default_nettype none
module fault_auto_retry_sequencer_test;
  import retry_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [FAULT_W-1:0] fault_i = '0;
  logic phase_missing_i = 1'b0;
  logic self_tune_i = 1'b0;
  logic vhz_ident_i = 1'b0;
  logic start_i, fault_reset_i, halt_key_i;
  logic run_o, faulted_o, countdown_o, irq_o;
  logic [FAULT_W-1:0] fault_code_o;
  logic [7:0] disp_prefix_o;
  logic [5:0] disp_seconds_o;
  logic [31:0] d;
  int fails = 0;
  int check_count = 0;
  always #10 clk_i = ~clk_i;
  operator_model u_op (.clk_i(clk_i), .start_o(start_i), .fault_reset_o(fault_reset_i),
    .halt_key_o(halt_key_i));
  retry_sequencer #(.TICK_CYCLES_P(10), .HEALTHY_S_P(4)) u_dut (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .fault_i(fault_i), .phase_missing_i(phase_missing_i),
    .start_i(start_i), .fault_reset_i(fault_reset_i), .halt_key_i(halt_key_i),
    .self_tune_i(self_tune_i), .vhz_ident_i(vhz_ident_i), .run_o(run_o),
    .faulted_o(faulted_o), .fault_code_o(fault_code_o), .countdown_o(countdown_o),
    .disp_prefix_o(disp_prefix_o), .disp_seconds_o(disp_seconds_o), .irq_o(irq_o));
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  // Bounded wait: 0 running, 1 faulted, 2 counting down
  task automatic wait_on(input int which, input int lim);
    int i;
    logic hit;
    i = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge clk_i);
      #1;
      hit = (which == 0) ? (run_o === 1'b1) : (which == 1) ? (faulted_o === 1'b1) :
        (countdown_o === 1'b1);
      i++;
      if (i > lim && !hit) begin
        fails++;
        final_report();
      end
    end
  endtask : wait_on
  task automatic inject(input int b);
    @(posedge clk_i);
    fault_i <= 16'h0001 << b;
    @(posedge clk_i);
    fault_i <= '0;
  endtask : inject
  task automatic retry_once;
    inject(FLT_OC_ACCEL);
    wait_on(2, 5);
    wait_on(0, 40);
  endtask : retry_once
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(REG_CTRL);
    check("ctrl_reset", d, 32'h0000_0480);
    rd(4'hF);
    check("unmapped", d, 32'h0);
    u_op.set_start(1'b1);
    wait_on(0, 5);
    inject(FLT_GROUND);
    wait_on(1, 5);
    check("code_lim0", {16'h0, fault_code_o}, 32'h0000_0004);
    u_op.clear_req(1'b1);
    wait_on(0, 5);
    wr(REG_CTRL, 32'h0000_0412);
    wr(REG_IRQ_STAT, 32'h0000_0007);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    inject(FLT_OC_ACCEL);
    wait_on(2, 5);
    check("prefix", {24'h0, disp_prefix_o}, 32'h0000_00A5);
    check("secs", {26'h0, disp_seconds_o}, 32'h0000_0001);
    check("irq", {31'h0, irq_o}, 32'h1);
    wait_on(0, 40);
    check("restart", {31'h0, run_o}, 32'h1);
    rd(REG_IRQ_STAT);
    check("irq_stat", d, 32'h0000_0003);
    rd(REG_FAULT_LOG);
    check("fault_log", d, 32'h0000_0100);
    rd(REG_STATUS);
    check("budget1", {28'h0, d[3:0]}, 32'h1);
    wr(REG_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge clk_i);
    check("irq_clr", {31'h0, irq_o}, 32'h0);
    repeat (70) @(posedge clk_i);
    rd(REG_STATUS);
    check("budget_reload", {28'h0, d[3:0]}, 32'h2);
    retry_once();
    retry_once();
    inject(FLT_OC_ACCEL);
    wait_on(1, 5);
    check("latched", {31'h0, countdown_o}, 32'h0);
    u_op.clear_req(1'b0);
    wait_on(0, 5);
    inject(FLT_OC_ACCEL);
    wait_on(2, 5);
    u_op.clear_req(1'b1);
    wait_on(0, 2);
    check("abort", {31'h0, countdown_o}, 32'h0);
    for (int k = 0; k < 3; k++) begin
      self_tune_i <= (k == 1);
      vhz_ident_i <= (k == 2);
      inject(k == 0 ? FLT_OTHER_A : FLT_LOW_BUS);
      wait_on(1, 5);
      check("no_retry", {31'h0, countdown_o}, 32'h0);
      self_tune_i <= 1'b0;
      vhz_ident_i <= 1'b0;
      u_op.clear_req(1'b1);
      wait_on(0, 5);
    end
    wr(REG_CTRL, 32'h0000_0012);
    phase_missing_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    check("phase_off", {31'h0, faulted_o}, 32'h0);
    wr(REG_CTRL, 32'h0000_0412);
    wait_on(1, 5);
    check("phase_on", {31'h0, fault_code_o[FLT_PHASE_LOSS]}, 32'h1);
    phase_missing_i <= 1'b0;
    wr(REG_CTRL, 32'h0000_000F);
    rd(REG_CTRL);
    check("clamp", d, 32'h0000_001A);
    final_report();
  end
endmodule : fault_auto_retry_sequencer_test
`default_nettype wire

// >>> testbench/operator_model.sv
// Operator keypad and run command source model
`timescale 1ns/1ps
`default_nettype none
module operator_model (
  input wire logic clk_i,
  output logic start_o,
  output logic fault_reset_o,
  output logic halt_key_o
);
  initial begin
    start_o = 1'b0;
    fault_reset_o = 1'b0;
    halt_key_o = 1'b0;
  end
  task automatic set_start(input logic v);
    @(posedge clk_i);
    start_o <= v;
  endtask : set_start
  // One-cycle clear request from keypad or control source
  task automatic clear_req(input logic key);
    @(posedge clk_i);
    halt_key_o <= key;
    fault_reset_o <= !key;
    @(posedge clk_i);
    halt_key_o <= 1'b0;
    fault_reset_o <= 1'b0;
  endtask : clear_req
endmodule : operator_model
`default_nettype wire
